// ===== src/radio_cfg_consts.svh
// Purpose: offsets, field positions, reset values of the radio config bank
// Assumes: 32-bit apb, word aligned registers
// Notes: definitions only
`ifndef RADIO_CFG_CONSTS_SVH
`define RADIO_CFG_CONSTS_SVH
`define OFS_TX_SELECT 12'h52c
`define OFS_RX_ENABLES 12'h530
`define OFS_CRC_SETUP 12'h534
`define OFS_CRC_POLY 12'h538
`define OFS_CRC_SEED 12'h53c
`define OFS_GAP 12'h544
`define OFS_RSSI 12'h548
`define OFS_STATE 12'h550
`define OFS_WHITE 12'h554
`define OFS_BCC 12'h560
`define CRC_LEN_LSB 0
`define CRC_LEN_MSB 1
`define CRC_SCOPE_LSB 8
`define CRC_SCOPE_MSB 9
`define WHITE_FIXED_BIT 6
`define RST_ZERO 32'h0000_0000
`define RST_WHITE 32'h0000_0040
`define POLY_MASK 32'h00ff_ffff
`endif

// ===== src/radio_cfg_pkg.sv
// Purpose: types of the radio config bank
// Assumes: nothing
// Notes: state codes encode the reported radio state
package radio_cfg_pkg;
	typedef enum logic [3:0] {
		ST_DISABLED = 4'h0,
		ST_RX_RU = 4'h1,
		ST_RX_IDLE = 4'h2,
		ST_RX = 4'h3,
		ST_RX_DIS = 4'h4,
		ST_TX_RU = 4'h9,
		ST_TX_IDLE = 4'ha,
		ST_TX = 4'hb,
		ST_TX_DIS = 4'hc
	} radio_state_type;
	typedef enum logic [1:0] {
		SCOPE_INCLUDE = 2'h0,
		SCOPE_SKIP = 2'h1,
		SCOPE_AFTER_LEN = 2'h2
	} crc_scope_type;
endpackage

// ===== src/radio_cfg_regs.sv
// Purpose: apb register bank for radio address, crc, whitening and state
// Assumes: core logic on same clock; state and rssi come from the radio core
// Notes: zero wait states, unmapped reads return zero with pslverr
//
// The APB slave port was chosen for this implementation.
`timescale 1ns/1ns
`include "radio_cfg_consts.svh"
module radio_cfg_regs (
	// clock and reset
	input wire logic CLK_I,
	input wire logic RST_N_I,
	// apb slave
	input wire logic PSEL_I,
	input wire logic PENABLE_I,
	input wire logic PWRITE_I,
	input wire logic [11:0] PADDR_I,
	input wire logic [31:0] PWDATA_I,
	output logic [31:0] PRDATA_O,
	output logic PREADY_O,
	output logic PSLVERR_O,
	// radio core status
	input wire radio_cfg_pkg::radio_state_type STATE_I,
	input wire logic [6:0] RSSI_I,
	input wire logic [2:0] BASE_LEN_I,
	// configuration to radio core
	output logic [2:0] TX_LOGICAL_SELECT_O,
	output logic [7:0] RX_LOGICAL_ENABLES_O,
	output logic [1:0] CRC_BYTE_COUNT_O,
	output logic CRC_ENABLE_O,
	output logic CRC_INCLUDE_ADDR_O,
	output logic CRC_AFTER_LENGTH_FIELD_O,
	output logic [23:0] CRC_POLYNOMIAL_O,
	output logic [23:0] CRC_SEED_O,
	output logic [9:0] INTERFRAME_GAP_US_O,
	output logic [6:0] WHITENING_LFSR_INIT_O,
	output logic [31:0] BIT_COUNT_COMPARE_O,
	output logic [2:0] ADDRESS_LENGTH_BYTES_O
);
	import radio_cfg_pkg::*;

	logic [2:0] tx_sel_q, tx_sel_d;
	logic [7:0] rx_en_q, rx_en_d;
	logic [1:0] crc_len_q, crc_len_d;
	logic [1:0] crc_scope_q, crc_scope_d;
	logic [23:0] poly_q, poly_d;
	logic [23:0] seed_q, seed_d;
	logic [9:0] gap_q, gap_d;
	logic [5:0] white_q, white_d;
	logic [31:0] bcc_q, bcc_d;
	logic [31:0] prdata_q, prdata_d;
	logic pready_q, pready_d;
	logic pslverr_q, pslverr_d;
	logic [6:0] rssi_q, rssi_d;
	radio_state_type state_q, state_d;
	logic [6:0] white_full;
	logic [6:0] white_next_full;
	logic [6:0] lfsr_next;
	logic [2:0] addr_len_q, addr_len_d;
	// derived crc and whitening controls
	logic crc_en_q, crc_en_d;
	logic incl_q, incl_d;
	logic after_len_q, after_len_d;
	logic [6:0] lfsr_q, lfsr_d;
	logic setup, wr, rd_req;
	logic mapped;
	// register selects
	logic sel_tx;
	logic sel_rx;
	logic sel_crc;
	logic sel_poly;
	logic sel_seed;
	logic sel_gap;
	logic sel_rssi;
	logic sel_state;
	logic sel_white;
	logic sel_bcc;

	assign setup = PSEL_I & ~PENABLE_I;
	assign wr = setup & PWRITE_I;
	assign rd_req = setup & ~PWRITE_I;
	assign white_full = {1'b1, white_q};
	assign white_next_full = {1'b1, white_d};

	genvar g;
	generate
		for (g = 0; g < 7; g++) begin : rev
			assign lfsr_next[6 - g] = white_next_full[g];
		end
	endgenerate

	// one select per mapped register
	always_comb begin
		sel_tx = 1'b0;
		sel_rx = 1'b0;
		sel_crc = 1'b0;
		sel_poly = 1'b0;
		sel_seed = 1'b0;
		sel_gap = 1'b0;
		sel_rssi = 1'b0;
		sel_state = 1'b0;
		sel_white = 1'b0;
		sel_bcc = 1'b0;
		case (PADDR_I)
			`OFS_TX_SELECT: sel_tx = 1'b1;
			`OFS_RX_ENABLES: sel_rx = 1'b1;
			`OFS_CRC_SETUP: sel_crc = 1'b1;
			`OFS_CRC_POLY: sel_poly = 1'b1;
			`OFS_CRC_SEED: sel_seed = 1'b1;
			`OFS_GAP: sel_gap = 1'b1;
			`OFS_RSSI: sel_rssi = 1'b1;
			`OFS_STATE: sel_state = 1'b1;
			`OFS_WHITE: sel_white = 1'b1;
			`OFS_BCC: sel_bcc = 1'b1;
			default: sel_tx = 1'b0;
		endcase
	end

	assign mapped = sel_tx | sel_rx | sel_crc | sel_poly | sel_seed | sel_gap | sel_rssi
		| sel_state | sel_white | sel_bcc;

	// configuration registers, next values
	always_comb begin
		tx_sel_d = tx_sel_q;
		rx_en_d = rx_en_q;
		crc_len_d = crc_len_q;
		crc_scope_d = crc_scope_q;
		poly_d = poly_q;
		seed_d = seed_q;
		gap_d = gap_q;
		white_d = white_q;
		bcc_d = bcc_q;
		if (wr) begin
			if (sel_tx) begin
				tx_sel_d = PWDATA_I[2:0];
			end
			if (sel_rx) begin
				rx_en_d = PWDATA_I[7:0];
			end
			if (sel_crc) begin
				crc_len_d = PWDATA_I[`CRC_LEN_MSB:`CRC_LEN_LSB];
				crc_scope_d = PWDATA_I[`CRC_SCOPE_MSB:`CRC_SCOPE_LSB];
			end
			if (sel_poly) begin
				poly_d = PWDATA_I[23:0];
			end
			if (sel_seed) begin
				seed_d = PWDATA_I[23:0];
			end
			if (sel_gap) begin
				gap_d = PWDATA_I[9:0];
			end
			if (sel_white) begin
				white_d = PWDATA_I[5:0];
			end
			if (sel_bcc) begin
				bcc_d = PWDATA_I;
			end
		end
	end

	always_ff @(posedge CLK_I) begin
		if (!RST_N_I) begin
			tx_sel_q <= 3'h0;
			rx_en_q <= 8'h00;
			crc_len_q <= 2'h0;
			crc_scope_q <= 2'h0;
			poly_q <= 24'h000000;
			seed_q <= 24'h000000;
			gap_q <= 10'h000;
			white_q <= 6'h00;
			bcc_q <= `RST_ZERO;
		end else begin
			tx_sel_q <= tx_sel_d;
			rx_en_q <= rx_en_d;
			crc_len_q <= crc_len_d;
			crc_scope_q <= crc_scope_d;
			poly_q <= poly_d;
			seed_q <= seed_d;
			gap_q <= gap_d;
			white_q <= white_d;
			bcc_q <= bcc_d;
		end
	end

	// sampled core status, next values
	always_comb begin
		rssi_d = RSSI_I;
		state_d = STATE_I;
		addr_len_d = BASE_LEN_I + 3'h1;
	end

	always_ff @(posedge CLK_I) begin
		if (!RST_N_I) begin
			rssi_q <= 7'h00;
			state_q <= ST_DISABLED;
			addr_len_q <= 3'h0;
		end else begin
			rssi_q <= rssi_d;
			state_q <= state_d;
			addr_len_q <= addr_len_d;
		end
	end

	// apb response, next values
	always_comb begin
		prdata_d = 32'h0000_0000;
		pready_d = setup;
		pslverr_d = setup & ~mapped;
		if (rd_req) begin
			case (PADDR_I)
				`OFS_TX_SELECT: prdata_d = {29'h0, tx_sel_q};
				`OFS_RX_ENABLES: prdata_d = {24'h0, rx_en_q};
				`OFS_CRC_SETUP: prdata_d = {22'h0, crc_scope_q, 6'h0, crc_len_q};
				`OFS_CRC_POLY: prdata_d = {8'h0, poly_q};
				`OFS_CRC_SEED: prdata_d = {8'h0, seed_q};
				`OFS_GAP: prdata_d = {22'h0, gap_q};
				`OFS_RSSI: prdata_d = {25'h0, rssi_q};
				`OFS_STATE: prdata_d = {28'h0, state_q};
				`OFS_WHITE: prdata_d = {25'h0, white_full};
				`OFS_BCC: prdata_d = bcc_q;
				default: prdata_d = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge CLK_I) begin
		if (!RST_N_I) begin
			prdata_q <= `RST_ZERO;
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
		end else begin
			prdata_q <= prdata_d;
			pready_q <= pready_d;
			pslverr_q <= pslverr_d;
		end
	end

	// derived controls follow the stored values on the same edge
	always_comb begin
		crc_en_d = (crc_len_d != 2'h0);
		incl_d = (crc_scope_d == SCOPE_INCLUDE);
		after_len_d = (crc_scope_d == SCOPE_AFTER_LEN);
		lfsr_d = lfsr_next;
	end

	always_ff @(posedge CLK_I) begin
		if (!RST_N_I) begin
			crc_en_q <= 1'b0;
			incl_q <= 1'b1;
			after_len_q <= 1'b0;
			lfsr_q <= 7'h01;
		end else begin
			crc_en_q <= crc_en_d;
			incl_q <= incl_d;
			after_len_q <= after_len_d;
			lfsr_q <= lfsr_d;
		end
	end

	assign PRDATA_O = prdata_q;
	assign PREADY_O = pready_q;
	assign PSLVERR_O = pslverr_q;
	assign TX_LOGICAL_SELECT_O = tx_sel_q;
	assign RX_LOGICAL_ENABLES_O = rx_en_q;
	assign CRC_BYTE_COUNT_O = crc_len_q;
	assign CRC_ENABLE_O = crc_en_q;
	assign CRC_INCLUDE_ADDR_O = incl_q;
	assign CRC_AFTER_LENGTH_FIELD_O = after_len_q;
	assign CRC_POLYNOMIAL_O = poly_q;
	assign CRC_SEED_O = seed_q;
	assign INTERFRAME_GAP_US_O = gap_q;
	assign WHITENING_LFSR_INIT_O = lfsr_q;
	assign BIT_COUNT_COMPARE_O = bcc_q;
	assign ADDRESS_LENGTH_BYTES_O = addr_len_q;
endmodule

// ===== testbench/radio_cfg_regs_sva.sv
// Purpose: port assertions of the radio config bank
// Assumes: a write is stored at its setup edge
// Notes: bound into radio_cfg_regs
`timescale 1ns/1ns
module radio_cfg_regs_sva (
	// clock, reset, apb, base length
	input wire logic CLK_I,
	input wire logic RST_N_I,
	input wire logic PSEL_I,
	input wire logic PENABLE_I,
	input wire logic PWRITE_I,
	input wire logic [11:0] PADDR_I,
	input wire logic [31:0] PWDATA_I,
	input wire logic PREADY_O,
	input wire logic [2:0] BASE_LEN_I,
	// configuration
	input wire logic [2:0] TX_LOGICAL_SELECT_O,
	input wire logic [1:0] CRC_BYTE_COUNT_O,
	input wire logic CRC_ENABLE_O,
	input wire logic CRC_INCLUDE_ADDR_O,
	input wire logic CRC_AFTER_LENGTH_FIELD_O,
	input wire logic [9:0] INTERFRAME_GAP_US_O,
	input wire logic [6:0] WHITENING_LFSR_INIT_O,
	input wire logic [2:0] ADDRESS_LENGTH_BYTES_O
);
	logic [31:0] w_q;
	always_ff @(posedge CLK_I) w_q <= PWDATA_I;
	default clocking @(posedge CLK_I); endclocking
	default disable iff (!RST_N_I);
	sequence wr(a);
		PSEL_I && !PENABLE_I && PWRITE_I && PADDR_I == a;
	endsequence
	AST_TXSEL: assert property (wr(12'h52c) |=> TX_LOGICAL_SELECT_O == w_q[2:0])
		else $error("tx select");
	AST_CLEN: assert property (wr(12'h534) |=> CRC_BYTE_COUNT_O == w_q[1:0]
		&& CRC_AFTER_LENGTH_FIELD_O == (w_q[9:8] == 2'h2)) else $error("crc setup");
	AST_SCOPE: assert property (wr(12'h534) |=> CRC_INCLUDE_ADDR_O == (w_q[9:8] == 2'h0))
		else $error("crc scope");
	AST_CEN: assert property (CRC_ENABLE_O == (CRC_BYTE_COUNT_O != 2'h0))
		else $error("crc enable");
	AST_GAP: assert property (wr(12'h544) |=> PREADY_O && INTERFRAME_GAP_US_O == w_q[9:0])
		else $error("gap");
	AST_LFSR: assert property (wr(12'h554) |=> WHITENING_LFSR_INIT_O ==
		{w_q[0], w_q[1], w_q[2], w_q[3], w_q[4], w_q[5], 1'h1}) else $error("lfsr");
	AST_RO: assert property ((wr(12'h550) or wr(12'h548)) |=>
		$stable({TX_LOGICAL_SELECT_O, INTERFRAME_GAP_US_O})) else $error("ro write");
	AST_ALEN: assert property ($past(RST_N_I) |->
		ADDRESS_LENGTH_BYTES_O == $past(BASE_LEN_I) + 3'h1) else $error("addr len");
endmodule
bind radio_cfg_regs radio_cfg_regs_sva i_radio_cfg_regs_sva (.*);

// ===== testbench/tb_radio_cfg_regs.sv
// Purpose: self-checking bench of the radio config bank
// Assumes: apb slave answers in the access phase
// Notes: no random stimulus
`timescale 1ns/1ns
module tb_radio_cfg_regs;
	import radio_cfg_pkg::*;
	logic CLK_I = 0, RST_N_I = 0, PSEL_I = 0, PENABLE_I = 0, PWRITE_I = 0;
	logic [11:0] PADDR_I = '0;
	logic [31:0] PWDATA_I = '0, PRDATA_O, BIT_COUNT_COMPARE_O, rd;
	logic PREADY_O, PSLVERR_O, CRC_ENABLE_O, CRC_INCLUDE_ADDR_O, CRC_AFTER_LENGTH_FIELD_O, er;
	radio_state_type STATE_I = ST_DISABLED;
	logic [6:0] RSSI_I = '0, WHITENING_LFSR_INIT_O;
	logic [2:0] BASE_LEN_I = '0, TX_LOGICAL_SELECT_O, ADDRESS_LENGTH_BYTES_O;
	logic [7:0] RX_LOGICAL_ENABLES_O;
	logic [1:0] CRC_BYTE_COUNT_O;
	logic [23:0] CRC_POLYNOMIAL_O, CRC_SEED_O;
	logic [9:0] INTERFRAME_GAP_US_O;
	logic [3:0] codes [9] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h9, 4'ha, 4'hb, 4'hc};
	int errors = 0, n_checks = 0;
	radio_cfg_regs i_radio_cfg_regs (.*);
	initial begin
		forever #4 CLK_I = ~CLK_I;
	end
	task chk(input logic [31:0] s, input logic [31:0] e, input string nm);
		n_checks++;
		if (s !== e) begin
			errors++;
			$display("[ERR] %s exp %h seen %h", nm, e, s);
		end
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge CLK_I);
		PSEL_I <= 1'h1;
		PWRITE_I <= w;
		PADDR_I <= a;
		PWDATA_I <= d;
		@(posedge CLK_I);
		PENABLE_I <= 1'h1;
		do begin
			@(posedge CLK_I);
		end while (PREADY_O !== 1'h1);
		rd = PRDATA_O;
		er = PSLVERR_O;
		PSEL_I <= 1'h0;
		PENABLE_I <= 1'h0;
	endtask
	task wrc(input logic [11:0] a, input logic [31:0] d, input logic [31:0] e);
		apb(1'h1, a, d);
		apb(1'h0, a, 32'h0);
		chk(rd, e, "readback");
	endtask
	task t_reset;
		apb(1'h0, 12'h53c, 32'h0);
		chk(rd, 32'h0, "seed");
		apb(1'h0, 12'h554, 32'h0);
		chk(rd, 32'h40, "white");
		chk(WHITENING_LFSR_INIT_O, 32'h1, "lfsr");
		chk(CRC_INCLUDE_ADDR_O, 32'h1, "scope");
		$display("t_reset done");
	endtask
	task t_cfg;
		logic [31:0] d;
		wrc(12'h52c, 32'h5, 32'h5);
		chk(TX_LOGICAL_SELECT_O, 32'h5, "txsel");
		wrc(12'h530, 32'ha5, 32'ha5);
		chk(RX_LOGICAL_ENABLES_O, 32'ha5, "rxen");
		for (int l = 0; l < 4; l++) begin
			for (int s = 0; s < 4; s++) begin
				d = {22'h0, s[1:0], 6'h0, l[1:0]};
				wrc(12'h534, d, d);
				chk(CRC_BYTE_COUNT_O, l, "count");
				chk(CRC_ENABLE_O, l != 0, "enable");
				chk(CRC_INCLUDE_ADDR_O, s == 0, "incl");
				chk(CRC_AFTER_LENGTH_FIELD_O, s == 2, "after");
			end
		end
		wrc(12'h534, 32'h3, 32'h3);
		chk(CRC_BYTE_COUNT_O, 32'h3, "count");
		wrc(12'h53c, 32'h00abcdef, 32'h00abcdef);
		chk(CRC_SEED_O, 32'h00abcdef, "seed");
		wrc(12'h538, 32'hffffffff, 32'h00ffffff);
		chk(CRC_POLYNOMIAL_O, 32'h00ffffff, "poly");
		wrc(12'h544, 32'h3ff, 32'h3ff);
		chk(INTERFRAME_GAP_US_O, 32'h3ff, "gap");
		wrc(12'h560, 32'h89abcdef, 32'h89abcdef);
		chk(BIT_COUNT_COMPARE_O, 32'h89abcdef, "bcc");
		$display("t_cfg done");
	endtask
	task t_state;
		for (int i = 0; i < 9; i++) begin
			STATE_I <= radio_state_type'(codes[i]);
			apb(1'h0, 12'h550, 32'h0);
			chk(rd, codes[i], "state");
		end
		RSSI_I <= 7'h2a;
		wrc(12'h550, 32'h3, 32'hc);
		wrc(12'h548, 32'h7f, 32'h2a);
		chk(TX_LOGICAL_SELECT_O, 32'h5, "txsel");
		$display("t_state done");
	endtask
	task t_white;
		wrc(12'h554, 32'h0, 32'h40);
		chk(WHITENING_LFSR_INIT_O, 32'h01, "lfsr");
		wrc(12'h554, 32'h25, 32'h65);
		chk(WHITENING_LFSR_INIT_O, 32'h53, "lfsr");
		BASE_LEN_I <= 3'h2;
		apb(1'h0, 12'h5fc, 32'h0);
		chk({rd[30:0], er}, 32'h1, "unmapped");
		chk(ADDRESS_LENGTH_BYTES_O, 32'h3, "alen");
		$display("t_white done");
	endtask
	task summarize;
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	initial begin
		repeat (20) @(posedge CLK_I);
		RST_N_I <= 1'h1;
		t_reset;
		t_cfg;
		t_state;
		t_white;
		summarize;
	end
	initial begin
		repeat (3000) @(posedge CLK_I);
		errors++;
		summarize;
	end
endmodule
